/* rtl/lsfa_frame_analyzer.sv */
`timescale 1ns/100ps
// ==========================================================================
// What this block does
// - Take 13-bit linear PCM, one per sample
// - Frame-to-output latency well under thirty milliseconds
// - Notch removes DC with 32735/32768 feedback
// - Pre-emphasis subtracts 28180/32768 of previous sample
// - 160-sample frames, one eighth-order analysis each
// - Nine autocorrelation lags summed within the frame
// - Schur recursion yields eight bounded reflection coefficients
// - Piecewise reflection to area-ratio mapping
// - Piecewise area-ratio back to reflection mapping
// - Scale, offset, round half away, then clamp
// - Scales and bounds for coefficients one to four
// - Scales and bounds for coefficients five to eight
// - Hold frame, replay it after parameters finish
// - Decode index: subtract offset, divide by scale
// - Blend previous and current decoded area values
// - Four coefficient sets across each frame
// - Indices packed first, widths 6,6,5,5,4,4,3,3
module lsfa_frame_analyzer (
	// Clock and reset
	input wire logic MCLK_I,
	input wire logic RESETN_I,
	// PCM sample input
	input wire logic PCM_VALID_I,
	input wire logic [lsfa_pkg::SAMPLE_W-1:0] PCM_DATA_I,
	output logic PCM_READY_O,
	// Coded parameter output
	output logic CODED_VALID_O,
	output logic [lsfa_pkg::CODED_W-1:0] CODED_O,
	// Replayed samples with their reflection coefficients
	output logic ST_VALID_O,
	output logic [lsfa_pkg::WORD_W-1:0] ST_SAMPLE_O,
	output logic [lsfa_pkg::NCOEF*lsfa_pkg::WORD_W-1:0] ST_COEF_O,
	input wire logic ST_READY_I
);
	import lsfa_pkg::*;

	// ======================================================================
	// Arithmetic helpers
	function automatic logic signed [47:0] clamp(input logic signed [47:0] v,
			input logic signed [47:0] hi);
		logic signed [47:0] lo;
		lo = -hi - 48'sh1;
		if (v > hi) return hi;
		if (v < lo) return lo;
		return v;
	endfunction : clamp

	function automatic logic signed [15:0] sat16(input logic signed [47:0] v);
		logic signed [47:0] t;
		t = clamp(v, SAT16_HI);
		return t[15:0];
	endfunction : sat16

	// Rounded Q15 product
	function automatic logic signed [15:0] mult_r(input logic signed [15:0] a,
			input logic signed [15:0] b);
		logic signed [47:0] p;
		p = 48'(a) * 48'(b);
		return sat16((p + RND_Q15) >>> Q15_SH);
	endfunction : mult_r

	function automatic logic [15:0] abs16(input logic signed [15:0] v);
		return (v < 0) ? 16'(sat16(-48'(v))) : 16'(v);
	endfunction : abs16

	// Reflection Q15 to area value Q14
	function automatic logic signed [15:0] refl2area(input logic signed [15:0] r);
		logic [15:0] a;
		logic [17:0] t;
		a = abs16(r);
		if (a < R_BRK1) t = 18'(a >> 1);
		else if (a < R_BRK2) t = 18'(a - HALF_BRK);
		else t = 18'({2'h0, a - TOP_OFS} << 2);
		return (r < 0) ? sat16(-48'(t)) : sat16(48'(t));
	endfunction : refl2area

	// Area value Q14 to reflection Q15
	function automatic logic signed [15:0] area2refl(input logic signed [15:0] x);
		logic [15:0] a;
		logic [17:0] t;
		a = abs16(x);
		if (a < HALF_BRK) t = 18'({2'h0, a} << 1);
		else if (a < L_BRK2) t = 18'(a) + 18'(HALF_BRK);
		else t = 18'(a >> 2) + 18'(TOP_OFS);
		return (x < 0) ? sat16(-48'(t)) : sat16(48'(t));
	endfunction : area2refl

	// Area value to coded index
	function automatic logic signed [7:0] quant(input logic signed [15:0] area,
			input int i);
		logic signed [47:0] t;
		t = (48'(QA[i]) * 48'(area)) >>> Q15_SH;
		t = t + 48'(QB[i]);
		if (t >= 0) t = (t + QRND) >>> QSH;
		else t = -((-t + QRND) >>> QSH);
		if (t < 48'(QMIN[i])) t = 48'(QMIN[i]);
		if (t > 48'(QMAX[i])) t = 48'(QMAX[i]);
		return t[7:0];
	endfunction : quant

	// Coded index back to area value Q14
	function automatic logic signed [15:0] decode(input logic signed [7:0] c,
			input int i);
		logic signed [47:0] num;
		num = (48'(c) <<< QSH) - 48'(QB[i]);
		// Inverse scale kept signed so negative numerators shift arithmetically
		return sat16((num * signed'(48'(QINV[i]))) >>> Q15_SH);
	endfunction : decode

	// Leading shift that puts the energy term just under the sign bit
	function automatic logic [5:0] lead_shift(input logic signed [ACC_W-1:0] v);
		logic [5:0] sh;
		sh = '0;
		for (int b = 0; b < ACC_W - 1; b++) begin
			if (v[b]) sh = 6'(ACC_W - 2 - b);
		end
		return sh;
	endfunction : lead_shift

	// ======================================================================
	// Buffers and handshakes
	logic inq_valid;                    // Input buffer has a sample
	logic [SAMPLE_W-1:0] inq_data;      // Oldest buffered sample
	logic fs_ready;                     // Frame store has room
	logic fs_valid;                     // Frame store has a sample
	logic [WORD_W-1:0] fs_data;         // Oldest stored sample
	logic pp_take;                      // Preprocessing may accept
	logic pp_fire;                      // A sample is processed this cycle
	logic fs_take;                      // Replay may pop the store
	logic cap;                          // Last sample of a frame arrives

	// Preprocessing state
	logic signed [15:0] so_prev_q, so_prev_d;   // Previous input sample
	logic signed [31:0] z2_q, z2_d;             // Notch output, Q15 extended
	logic signed [15:0] sof_prev_q, sof_prev_d; // Previous offset-free sample
	logic signed [15:0] hist_q [NCOEF];         // Last eight emphasized samples
	logic signed [15:0] hist_d [NCOEF];
	logic signed [ACC_W-1:0] corr_q [NLAG]; // Running correlations
	logic signed [ACC_W-1:0] corr_d [NLAG];
	logic signed [ACC_W-1:0] corr_sum [NLAG]; // Sums including this sample
	logic [7:0] fcnt_q, fcnt_d;                 // Sample index within frame
	logic signed [15:0] so_c, offset_free_sample, s_c;
	logic signed [47:0] w48;

	// Engine state
	lsfa_state_t state_q, state_d;
	logic signed [15:0] p_q [NLAG], p_d [NLAG];     // Schur P terms
	logic signed [15:0] k_q [NCOEF], k_d [NCOEF];   // Schur K terms, K1 first
	logic signed [15:0] r_q [NCOEF], r_d [NCOEF];   // Reflection coefficients
	logic [2:0] n_q, n_d;                           // Coefficient in progress
	logic [3:0] step_q, step_d;                     // Division step
	logic [16:0] rem_q, rem_d;                      // Division remainder
	logic [14:0] quo_q, quo_d;                      // Division quotient
	logic signed [15:0] dec_prev_q [NCOEF], dec_prev_d [NCOEF];
	logic signed [15:0] decoded_area_value [NCOEF], dec_cur_d [NCOEF];
	logic [7:0] rp_q, rp_d;                         // Replay sample index
	logic coded_valid_q, coded_valid_d;
	logic [CODED_W-1:0] coded_q, coded_d;
	logic st_valid_q, st_valid_d;
	logic [WORD_W-1:0] st_sample_q, st_sample_d;
	logic [NCOEF*WORD_W-1:0] st_coef_q, st_coef_d;
	logic signed [ACC_W-1:0] norm;
	logic [5:0] sh;
	logic [15:0] num;
	logic signed [15:0] rq, area, blend;
	logic signed [7:0] coded_area_index;
	logic [16:0] rem2;
	logic signed [16:0] mix;

	// ======================================================================
	// Buffers
	// Input buffer absorbs bursts; its ready is the source's back-pressure
	lsfa_fifo #(.WIDTH(SAMPLE_W), .DEPTH(IN_FIFO_DEPTH)) u_in_fifo (
		.clk_i(MCLK_I), .rst_n_i(RESETN_I),
		.in_valid_i(PCM_VALID_I), .in_data_i(PCM_DATA_I), .in_ready_o(PCM_READY_O),
		.out_valid_o(inq_valid), .out_data_o(inq_data), .out_ready_i(pp_take)
	);

	// Frame store keeps the whole frame until its parameters exist
	lsfa_fifo #(.WIDTH(WORD_W), .DEPTH(FS_DEPTH)) u_frame_store (
		.clk_i(MCLK_I), .rst_n_i(RESETN_I),
		.in_valid_i(pp_fire), .in_data_i(s_c), .in_ready_o(fs_ready),
		.out_valid_o(fs_valid), .out_data_o(fs_data), .out_ready_i(fs_take)
	);

	// A frame cannot close while the engine still owns the previous one
	assign pp_take = fs_ready && !(fcnt_q == 8'(FRAME_LAST) && state_q != ST_IDLE);
	assign pp_fire = inq_valid && pp_take;
	assign cap = pp_fire && (fcnt_q == 8'(FRAME_LAST));
	assign fs_take = (state_q == ST_REPLAY) && (!st_valid_q || ST_READY_I);

	// ======================================================================
	// Preprocessing and correlation, one sample per accepted strobe
	always_comb begin
		so_c = signed'({inq_data, PCM_PAD});
		w48 = 48'(so_c) - 48'(so_prev_q);
		w48 = (w48 <<< Q15_SH) + ((48'(z2_q) * 48'(ALPHA) + RND_Q15) >>> Q15_SH);
		w48 = clamp(w48, SAT32_HI);
		z2_d = w48[31:0];
		offset_free_sample = sat16((48'(z2_d) + RND_Q15) >>> Q15_SH);
		s_c = sat16(48'(offset_free_sample) - 48'(mult_r(sof_prev_q, BETA)));
		so_prev_d = so_prev_q;
		sof_prev_d = sof_prev_q;
		fcnt_d = fcnt_q;
		hist_d = hist_q;
		corr_d = corr_q;
		for (int l = 0; l < NLAG; l++) begin
			// Lag products only from samples of the same frame
			if (fcnt_q >= 8'(l)) begin
				w48 = 48'(s_c) * ((l == 0) ? 48'(s_c) : 48'(hist_q[(l == 0) ? 0 : l - 1]));
				w48 = clamp(48'(corr_q[l]) + w48, SAT40_HI);
			end else begin
				w48 = 48'(corr_q[l]);
			end
			corr_sum[l] = w48[ACC_W-1:0];
		end
		if (pp_fire) begin
			so_prev_d = so_c;
			sof_prev_d = offset_free_sample;
			hist_d[0] = s_c;
			for (int m = 1; m < NCOEF; m++) hist_d[m] = hist_q[m-1];
			if (cap) begin
				fcnt_d = '0;
				for (int l = 0; l < NLAG; l++) corr_d[l] = '0;
			end else begin
				fcnt_d = fcnt_q + 8'h01;
				corr_d = corr_sum;
			end
		end
		if (!pp_fire) z2_d = z2_q;
	end

	always_ff @(posedge MCLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			so_prev_q <= '0;
			z2_q <= '0;
			sof_prev_q <= '0;
			fcnt_q <= '0;
			for (int m = 0; m < NCOEF; m++) hist_q[m] <= '0;
			for (int l = 0; l < NLAG; l++) corr_q[l] <= '0;
		end else begin
			so_prev_q <= so_prev_d;
			z2_q <= z2_d;
			sof_prev_q <= sof_prev_d;
			fcnt_q <= fcnt_d;
			hist_q <= hist_d;
			corr_q <= corr_d;
		end
	end

	// ======================================================================
	// Analysis engine: Schur, area ratios, coding, then replay
	always_comb begin
		state_d = state_q;
		p_d = p_q;
		k_d = k_q;
		r_d = r_q;
		n_d = n_q;
		step_d = step_q;
		rem_d = rem_q;
		quo_d = quo_q;
		dec_prev_d = dec_prev_q;
		dec_cur_d = decoded_area_value;
		rp_d = rp_q;
		coded_d = coded_q;
		coded_valid_d = 1'b0;
		st_sample_d = st_sample_q;
		st_coef_d = st_coef_q;
		st_valid_d = st_valid_q && !ST_READY_I;
		sh = lead_shift(corr_sum[0]);
		norm = '0;
		num = abs16(p_q[1]);
		rem2 = {rem_q[15:0], 1'b0};
		rq = '0;
		area = '0;
		blend = '0;
		mix = '0;
		coded_area_index = '0;
		unique case (state_q)
			// Wait for a closed frame, then normalise its correlations
			ST_IDLE: begin
				if (cap) begin
					for (int l = 0; l < NLAG; l++) begin
						norm = corr_sum[l] <<< sh;
						p_d[l] = norm[ACC_W-1 -: WORD_W];
						if (l > 0) k_d[l-1] = norm[ACC_W-1 -: WORD_W];
					end
					rem_d = {1'b0, abs16(p_d[1])};
					quo_d = '0;
					step_d = '0;
					n_d = '0;
					state_d = ST_DIV;
				end
			end
			// Restoring division, one quotient bit a cycle
			ST_DIV: begin
				if (rem2 >= {1'b0, p_q[0]}) begin
					rem_d = rem2 - {1'b0, p_q[0]};
					quo_d = {quo_q[13:0], 1'b1};
				end else begin
					rem_d = rem2;
					quo_d = {quo_q[13:0], 1'b0};
				end
				step_d = step_q + 4'h1;
				if (step_q == 4'(DIV_LAST)) state_d = ST_UPD;
			end
			// Finish one coefficient and advance the recursion
			ST_UPD: begin
				if (p_q[0] == 0) rq = '0;
				else if (num >= 16'(p_q[0])) rq = Q15_MAX;
				else rq = signed'({1'b0, quo_q});
				if (p_q[1] > 0) rq = -rq;
				r_d[n_q] = rq;
				p_d[0] = sat16(48'(p_q[0]) + 48'(mult_r(p_q[1], rq)));
				for (int m = 1; m < NCOEF; m++) begin
					if (m <= 7 - int'(n_q)) begin
						p_d[m] = sat16(48'(p_q[m+1]) + 48'(mult_r(k_q[m-1], rq)));
						k_d[m-1] = sat16(48'(k_q[m-1]) + 48'(mult_r(p_q[m+1], rq)));
					end
				end
				rem_d = {1'b0, abs16(p_d[1])};
				quo_d = '0;
				step_d = '0;
				n_d = n_q + 3'h1;
				state_d = (n_q == 3'(NCOEF - 1)) ? ST_CODE : ST_DIV;
			end
			// Convert, code, pack and decode all eight at once
			ST_CODE: begin
				coded_d = '0;
				for (int i = 0; i < NCOEF; i++) begin
					area = refl2area(r_q[i]);
					coded_area_index = quant(area, i);
					coded_d = (coded_d << QW[i])
						| CODED_W'(coded_area_index & ((8'h1 << QW[i]) - 8'h1));
					dec_prev_d[i] = decoded_area_value[i];
					dec_cur_d[i] = decode(coded_area_index, i);
				end
				coded_valid_d = 1'b1;
				rp_d = '0;
				state_d = ST_REPLAY;
			end
			// Replay the held frame with blended coefficients
			ST_REPLAY: begin
				if (fs_valid && fs_take) begin
					for (int i = 0; i < NCOEF; i++) begin
						if (rp_q <= 8'(SEG1_END)) begin
							mix = 17'(dec_prev_q[i] >>> 1) + 17'(dec_prev_q[i] >>> 2)
								+ 17'(decoded_area_value[i] >>> 2);
						end else if (rp_q <= 8'(SEG2_END)) begin
							mix = 17'(dec_prev_q[i] >>> 1) + 17'(decoded_area_value[i] >>> 1);
						end else if (rp_q <= 8'(SEG3_END)) begin
							mix = 17'(dec_prev_q[i] >>> 2) + 17'(decoded_area_value[i] >>> 1)
								+ 17'(decoded_area_value[i] >>> 2);
						end else begin
							mix = 17'(decoded_area_value[i]);
						end
						blend = sat16(48'(mix));
						st_coef_d[i*WORD_W +: WORD_W] = area2refl(blend);
					end
					st_sample_d = fs_data;
					st_valid_d = 1'b1;
					rp_d = rp_q + 8'h01;
					if (rp_q == 8'(FRAME_LAST)) state_d = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge MCLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			state_q <= ST_IDLE;
			for (int l = 0; l < NLAG; l++) p_q[l] <= '0;
			for (int i = 0; i < NCOEF; i++) begin
				k_q[i] <= '0;
				r_q[i] <= '0;
				dec_prev_q[i] <= '0;
				decoded_area_value[i] <= '0;
			end
			n_q <= '0;
			step_q <= '0;
			rem_q <= '0;
			quo_q <= '0;
			rp_q <= '0;
			coded_valid_q <= 1'b0;
			coded_q <= '0;
			st_valid_q <= 1'b0;
			st_sample_q <= '0;
			st_coef_q <= '0;
		end else begin
			state_q <= state_d;
			p_q <= p_d;
			k_q <= k_d;
			r_q <= r_d;
			dec_prev_q <= dec_prev_d;
			decoded_area_value <= dec_cur_d;
			n_q <= n_d;
			step_q <= step_d;
			rem_q <= rem_d;
			quo_q <= quo_d;
			rp_q <= rp_d;
			coded_valid_q <= coded_valid_d;
			coded_q <= coded_d;
			st_valid_q <= st_valid_d;
			st_sample_q <= st_sample_d;
			st_coef_q <= st_coef_d;
		end
	end

	// Outputs straight from registers
	assign CODED_VALID_O = coded_valid_q;
	assign CODED_O = coded_q;
	assign ST_VALID_O = st_valid_q;
	assign ST_SAMPLE_O = st_sample_q;
	assign ST_COEF_O = st_coef_q;

endmodule : lsfa_frame_analyzer

/* shared/lsfa_pkg.sv */
// ==========================================================================
// Constants shared by the frame analyzer and its buffers
package lsfa_pkg;

	// ======================================================================
	// Widths and frame shape
	localparam int SAMPLE_W = 13;          // Linear PCM width at the input
	localparam int WORD_W = 16;            // Working sample and Q15 width
	localparam int ACC_W = 40;             // Correlation accumulator width
	localparam int NCOEF = 8;              // Prediction order
	localparam int NLAG = 9;               // Lags 0..8
	localparam int FRAME_LAST = 159;       // Last sample index of a frame
	localparam int SEG1_END = 12;          // Last sample of the 3:1 blend
	localparam int SEG2_END = 26;          // Last sample of the 1:1 blend
	localparam int SEG3_END = 39;          // Last sample of the 1:3 blend
	localparam int IN_FIFO_DEPTH = 8;      // Input buffer depth, power of two
	localparam int FS_DEPTH = 256;         // Frame store depth, power of two
	localparam int CODED_W = 36;           // Packed coded indices
	localparam int DIV_LAST = 14;          // Fifteen quotient bits
	localparam logic [2:0] PCM_PAD = 3'h0; // 13-bit input sits left aligned

	// ======================================================================
	// Fixed-point helpers
	localparam int Q15_SH = 15;
	localparam logic signed [47:0] RND_Q15 = 48'sh4000;
	localparam logic signed [47:0] SAT16_HI = 48'sh7FFF;
	localparam logic signed [47:0] SAT32_HI = 48'sh7FFFFFFF;
	localparam logic signed [47:0] SAT40_HI = 48'sh7FFFFFFFFF;
	localparam logic signed [15:0] Q15_MAX = 16'sh7FFF;

	// ======================================================================
	// Filter coefficients, Q15
	localparam logic signed [15:0] ALPHA = 16'sh7FDF;  // 32735 / 32768
	localparam logic signed [15:0] BETA = 16'sh6E14;   // 28180 / 32768

	// ======================================================================
	// Area-ratio breakpoints: reflection in Q15, area value in Q14
	localparam logic [15:0] R_BRK1 = 16'h5666;  // 0.675 in Q15
	localparam logic [15:0] R_BRK2 = 16'h799A;  // 0.950 in Q15
	localparam logic [15:0] HALF_BRK = 16'h2B33; // 0.675 Q14, also 0.3375 Q15
	localparam logic [15:0] TOP_OFS = 16'h6600; // 6.375 Q12, also 0.796875 Q15
	localparam logic [15:0] L_BRK2 = 16'h4E66;  // 1.225 in Q14

	// ======================================================================
	// Quantizer: scale times 1024, offset times 512, inverse scale 2^30/A
	localparam logic signed [15:0] QA [NCOEF] = '{16'sh5000, 16'sh5000, 16'sh5000,
		16'sh5000, 16'sh368C, 16'sh3C00, 16'sh2156, 16'sh234C};
	localparam logic signed [15:0] QB [NCOEF] = '{16'sh0000, 16'sh0000, 16'sh0800,
		16'shF600, 16'sh005E, 16'shF900, 16'shFEAB, 16'shFB88};
	localparam logic [17:0] QINV [NCOEF] = '{18'h0CCCD, 18'h0CCCD, 18'h0CCCD,
		18'h0CCCD, 18'h12C5E, 18'h11111, 18'h1EB7B, 18'h1D02D};
	localparam logic signed [7:0] QMIN [NCOEF] = '{8'shE0, 8'shE0, 8'shF0, 8'shF0,
		8'shF8, 8'shF8, 8'shFC, 8'shFC};
	localparam logic signed [7:0] QMAX [NCOEF] = '{8'sh1F, 8'sh1F, 8'sh0F, 8'sh0F,
		8'sh07, 8'sh07, 8'sh03, 8'sh03};
	localparam int QW [NCOEF] = '{6, 6, 5, 5, 4, 4, 3, 3};
	localparam int QSH = 9;                             // z carries 9 fraction bits
	localparam logic signed [47:0] QRND = 48'sh100;     // Half of one step

	// ======================================================================
	// Engine states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DIV,
		ST_UPD,
		ST_CODE,
		ST_REPLAY
	} lsfa_state_t;

endpackage : lsfa_pkg

/* rtl/lsfa_fifo.sv */
`timescale 1ns/100ps
// ==========================================================================
// Valid/ready FIFO with registered read data; DEPTH must be a power of two
module lsfa_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Filling side
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	// Draining side
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];   // Storage, not reset
	logic [AW-1:0] wr_q, wr_d;         // Write pointer
	logic [AW-1:0] rd_q, rd_d;         // Read pointer
	logic [AW:0] cnt_q, cnt_d;         // Words held in storage
	logic ready_q, ready_d;            // Registered room flag
	logic ov_q, ov_d;                  // Output register holds a word
	logic [WIDTH-1:0] od_q, od_d;      // Output register
	logic push;
	logic load;

	// ======================================================================
	// Next state; the output stage adds one word of capacity
	always_comb begin
		push = in_valid_i && ready_q;
		load = (cnt_q != '0) && (!ov_q || out_ready_i);
		wr_d = push ? wr_q + 1'b1 : wr_q;
		rd_d = load ? rd_q + 1'b1 : rd_q;
		cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(load);
		// Room is judged on the next count so ready never lies
		ready_d = (cnt_d != (AW+1)'(DEPTH));
		if (load) begin
			ov_d = 1'b1;
		end else if (out_ready_i) begin
			ov_d = 1'b0;
		end else begin
			ov_d = ov_q;
		end
		od_d = load ? mem_q[rd_q] : od_q;
	end

	// ======================================================================
	// Control registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			ready_q <= 1'b0;
			ov_q <= 1'b0;
			od_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
			ready_q <= ready_d;
			ov_q <= ov_d;
			od_q <= od_d;
		end
	end

	// Storage write, no reset so it maps to RAM
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_q[wr_q] <= in_data_i;
		end
	end

	assign in_ready_o = ready_q;
	assign out_valid_o = ov_q;
	assign out_data_o = od_q;

endmodule : lsfa_fifo

/* dv/lsfa_frame_monitor.sv */
`timescale 1ns/100ps
// ==========================================================================
// Port watcher: pulse shape, holds, frame counts
module lsfa_frame_monitor (
	input wire logic MCLK_I,
	input wire logic RESETN_I,
	input wire logic PCM_VALID_I,
	input wire logic PCM_READY_O,
	input wire logic CODED_VALID_O,
	input wire logic [35:0] CODED_O,
	input wire logic ST_VALID_O,
	input wire logic [15:0] ST_SAMPLE_O,
	input wire logic [127:0] ST_COEF_O,
	input wire logic ST_READY_I
);
	int tk_q; // Samples taken
	int fr_q; // Coded pulses seen
	int st_q; // Replayed since last pulse
	always_ff @(posedge MCLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			tk_q <= 0;
			fr_q <= 0;
			st_q <= 0;
		end else begin
			tk_q <= tk_q + int'(PCM_VALID_I && PCM_READY_O);
			fr_q <= fr_q + int'(CODED_VALID_O);
			st_q <= CODED_VALID_O ? 0 : st_q + int'(ST_VALID_O && ST_READY_I);
		end
	end
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (!RESETN_I);
	pulse_once_a: assert property (CODED_VALID_O |=> !CODED_VALID_O)
		else $error("coded pulse too long");
	coded_hold_a: assert property (!CODED_VALID_O |-> $stable(CODED_O))
		else $error("coded word moved");
	st_hold_a: assert property (ST_VALID_O && !ST_READY_I |=> ST_VALID_O
		&& $stable(ST_SAMPLE_O) && $stable(ST_COEF_O)) else $error("replay dropped");
	replay_start_a: assert property (CODED_VALID_O |=> ST_VALID_O)
		else $error("replay late");
	frame_fill_a: assert property (CODED_VALID_O |-> tk_q >= 160 * (fr_q + 1))
		else $error("frame closed early");
	frame_replay_a: assert property (CODED_VALID_O && fr_q > 0 |-> st_q == 160)
		else $error("replay count wrong");
	replay_cap_a: assert property (ST_VALID_O |-> st_q < 160)
		else $error("replay overrun");
	early_replay_a: assert property (ST_VALID_O |-> fr_q > 0)
		else $error("replay before coding");
	cover property (CODED_VALID_O && fr_q > 1);
	cover property (ST_VALID_O && !ST_READY_I);
	cover property (PCM_VALID_I && !PCM_READY_O);
endmodule : lsfa_frame_monitor

bind lsfa_frame_analyzer lsfa_frame_monitor mon (.MCLK_I, .RESETN_I, .PCM_VALID_I,
	.PCM_READY_O, .CODED_VALID_O, .CODED_O, .ST_VALID_O, .ST_SAMPLE_O, .ST_COEF_O, .ST_READY_I);

/* dv/lsfa_stream_partner.sv */
`timescale 1ns/100ps
// ==========================================================================
// Sample source and stalling sink; one silent frame first, then noise
module lsfa_stream_partner (
	input wire logic clk_i,
	input wire logic rdy_i,
	output logic valid_o,
	output logic [12:0] data_o,
	output logic st_ready_o
);
	logic [31:0] x = 32'h10E95; // Xorshift state
	logic tk = 1'b0; // Held sample taken
	int n = 0; // Samples offered
	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction : xs
	initial begin
		valid_o = 1'b0;
		data_o = 13'h0;
		st_ready_o = 1'b0;
	end
	always @(posedge clk_i) tk = valid_o && rdy_i;
	// Hold each sample until taken, one per strobe
	always @(negedge clk_i) begin
		x = xs(x);
		st_ready_o <= x[0] | x[1]; // Stall a quarter of cycles
		if (!valid_o || tk) begin
			valid_o <= 1'b1;
			data_o <= (n < 160) ? 13'h0 : x[31:19];
			n <= n + 1;
		end
	end
endmodule : lsfa_stream_partner

/* dv/lsfa_frame_analyzer_tb.sv */
`timescale 1ns/100ps
// ==========================================================================
// Three frames: silent frame code checked exactly, its replay within slack, then counts and latency
module lsfa_frame_analyzer_tb;
	logic clk, rst_n, v, srdy, rdy, cv, sv;
	logic [12:0] d;
	logic [35:0] cod;
	logic [15:0] ss;
	logic [127:0] sc;
	int n_fail, checks, n_st, n_cod, n_tk, t_tk, cyc;
	int e; // Expected coefficient
	int q_s[$]; // Expected replay samples, input order
	real so, sp, zf, sf, w; // Filter model state and blend weight
	// Silent-frame indices five to eight with their scales and offsets
	int ci[4] = '{0, -4, -1, -2};
	real ra[4] = '{13.637, 15.0, 8.334, 8.824};
	real rb[4] = '{0.184, -3.5, -0.666, -2.235};
	// Nint of each offset on silence, half away from zero
	logic [35:0] exp_c = {6'h00, 6'h00, 5'h04, 5'h1B, 4'h0, 4'hC, 3'h7, 3'h6};
	lsfa_frame_analyzer dut (.MCLK_I(clk), .RESETN_I(rst_n), .PCM_VALID_I(v),
		.PCM_DATA_I(d), .PCM_READY_O(rdy), .CODED_VALID_O(cv), .CODED_O(cod),
		.ST_VALID_O(sv), .ST_SAMPLE_O(ss), .ST_COEF_O(sc), .ST_READY_I(srdy));
	lsfa_stream_partner src (.clk_i(clk), .rdy_i(rdy), .valid_o(v), .data_o(d),
		.st_ready_o(srdy));
	task chk(input string w, input logic [127:0] e, input logic [127:0] s);
		checks++;
		if (e !== s) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", w, e, s);
		end
	endtask : chk
	// Fixed-point rounding allows a few steps of slack
	task near(input string w, input int e, input logic [15:0] s);
		checks++;
		if ($isunknown(s) || signed'(s) < e - 8 || signed'(s) > e + 8) begin
			n_fail++;
			$display("[ERR] %s exp %0d got %0d", w, e, signed'(s));
		end
	endtask : near
	function automatic real lim(input real v, input real h);
		return (v > h) ? h : ((v < -h) ? -h : v);
	endfunction : lim
	task print_verdict;
		$display("checks %0d fails %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : print_verdict
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		rst_n = 1'b0;
		repeat (2) @(posedge clk);
		@(negedge clk) rst_n = 1'b1;
		wait (n_cod == 3);
		@(negedge clk);
		print_verdict();
	end
	initial begin
		#3000000;
		n_fail++;
		$display("[ERR] watchdog exp done got hang");
		print_verdict();
	end
	// Reference model, compared at every replayed sample
	always @(posedge clk) if (rst_n) begin
		cyc++;
		if (v && rdy) begin
			// Notch then pre-emphasis on the input widened to 16 bits
			so = 8.0 * $signed(d);
			zf = lim(so - sp + 32735.0 / 32768.0 * zf, 65536.0);
			sp = so;
			so = lim($floor(zf + 0.5), 32767.0);
			q_s.push_back($rtoi(lim(so - 28180.0 / 32768.0 * sf, 32767.0)));
			sf = so;
			if (++n_tk % 160 == 0) t_tk = cyc;
		end
		if (sv && srdy) begin
			near("replay sample", q_s.pop_front(), ss);
			if (n_cod == 1) begin
				chk("silent replay", 80'h0, {ss, sc[63:0]});
				w = (n_st <= 12) ? 0.25 : (n_st <= 26) ? 0.5 : (n_st <= 39) ? 0.75 : 1.0;
				for (int i = 0; i < 4; i++) begin
					e = $rtoi(w * (ci[i] - rb[i]) / ra[i] * 32768.0);
					near("silent coef", e, sc[64 + 16 * i +: 16]);
				end
			end
			n_st++;
		end
		if (cv) begin
			if (n_cod == 0) chk("silent code", exp_c, cod);
			if (n_cod > 0) chk("replay count", 160, n_st);
			chk("latency", 1, cyc - t_tk < 300000);
			n_st = 0;
			n_cod++;
			$display("frame %0d done", n_cod);
		end
	end
endmodule : lsfa_frame_analyzer_tb
